//--- udo_pkg.sv
// Purpose: Shared constants and types for the drive-side data-out burst handshake.
// Assumes: A 125 MHz core clock; all link pins arrive asynchronously.
// Notes:   Timing constants are given in ns and converted to cycles here.

package udo_pkg;

  localparam int          DATA_W        = 16;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          RESERVE_WORDS = 3;
  localparam int          LEVEL_W       = 5;
  localparam logic [4:0]  PAUSE_LEVEL   = 5'(FIFO_DEPTH - RESERVE_WORDS - 1);

  localparam logic [15:0] CRC_SEED      = 16'h4ABA;
  localparam logic [15:0] CRC_POLY      = 16'h1021;

  localparam int          CLK_PERIOD_NS = 8;
  localparam int          T_RP_NS       = 160;
  localparam int          RP_CYCLES     = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  RP_LOAD       = 8'(RP_CYCLES - 1);

  localparam int          ERR_ICRC_BIT  = 7;
  localparam int          ERR_ABRT_BIT  = 2;
  localparam logic [7:0]  ERR_RST       = 8'h00;

  localparam int          SYNC_W        = DATA_W + 3;
  localparam logic [18:0] SYNC_RST      = {1'b0, 1'b0, 1'b1, 16'h0000};

  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b000,
    ST_REQ     = 3'b001,
    ST_XFER    = 3'b010,
    ST_PAUSE   = 3'b011,
    ST_RP_WAIT = 3'b100,
    ST_HALT    = 3'b101
  } udo_state_e;

endpackage : udo_pkg

//--- udo_fifo.sv
// Purpose: Small word buffer with registered read data.
// Assumes: Single clock; writes are dropped while full.
// Notes:   level_out counts words held in the memory, not the output register.

module udo_fifo
  import udo_pkg::*;
#(
  parameter int W = 16,
  parameter int D = 16
)
(
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] wr_data_in,
  input  wire logic         wr_valid_in,
  output logic              wr_ready_out,
  output logic [W-1:0]      rd_data_out,
  output logic              rd_valid_out,
  input  wire logic         rd_ready_in,
  output logic [$clog2(D):0] level_out
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  assign wr_ready_out = (count_reg != (AW+1)'(D));
  assign level_out    = count_reg;
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = (count_reg != '0) && (!rd_valid_out || rd_ready_in);

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg  <= rd_ptr_reg + 1'b1;
        rd_data_out <= mem_reg[rd_ptr_reg];
      end
      if (pop)
      begin
        rd_valid_out <= 1'b1;
      end
      else if (rd_ready_in)
      begin
        rd_valid_out <= 1'b0;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : udo_fifo

//--- udo_dout.sv
// Purpose: Drive-side handshake for data-out bursts: pause, termination, CRC check.
// Assumes: Host pins are asynchronous and slow against the core clock.
// Notes:   Strobe edges are found by oversampling; data is taken one stage late.

module udo_dout
  import udo_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              hstrobe_in,
  input  wire logic              stop_in,
  input  wire logic              dmack_n_in,
  input  wire logic [DATA_W-1:0] dd_in,
  output logic                   dmarq_out,
  output logic                   ddmardy_n_out,
  output logic                   ddmardy_oe_out,
  input  wire logic              burst_req_in,
  input  wire logic              pause_req_in,
  input  wire logic              term_req_in,
  input  wire logic              cmd_start_in,
  input  wire logic              cmd_end_in,
  output logic [DATA_W-1:0]      word_out,
  output logic                   word_valid_out,
  input  wire logic              word_ready_in,
  output logic                   burst_active_out,
  output logic                   burst_done_out,
  output logic                   crc_err_out,
  output logic                   overrun_out,
  output logic [7:0]             err_reg_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync3_reg;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      sync3_reg <= SYNC_RST;
    end
    else
    begin
      sync1_reg <= {hstrobe_in, stop_in, dmack_n_in, dd_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic              strobe_edge;
  logic              stop_lvl;
  logic              dmack_act;
  logic              dmack_rise;
  logic [DATA_W-1:0] data_word;

  assign strobe_edge = sync2_reg[18] ^ sync3_reg[18];
  assign stop_lvl    = sync2_reg[17];
  assign dmack_act   = !sync2_reg[16];
  assign dmack_rise  = sync2_reg[16] && !sync3_reg[16];
  assign data_word   = sync3_reg[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Word buffer.

  logic           take_word;
  logic           fifo_wr_ready;
  logic [LEVEL_W-1:0] fifo_level;
  logic           near_full;

  udo_fifo #(
    .W (DATA_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .wr_data_in   (data_word),
    .wr_valid_in  (take_word),
    .wr_ready_out (fifo_wr_ready),
    .rd_data_out  (word_out),
    .rd_valid_out (word_valid_out),
    .rd_ready_in  (word_ready_in),
    .level_out    (fifo_level)
  );

  assign near_full = (fifo_level >= PAUSE_LEVEL) || !fifo_wr_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // Burst state machine.

  udo_state_e state_reg;
  udo_state_e state_next;
  logic       got_word_reg;
  logic [7:0] rp_cnt_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (burst_req_in)
        begin
          state_next = ST_REQ;
        end
      end
      ST_REQ:
      begin
        if (dmack_act && !stop_lvl)
        begin
          state_next = ST_XFER;
        end
      end
      ST_XFER:
      begin
        if (stop_lvl)
        begin
          state_next = ST_HALT;
        end
        else if (got_word_reg && term_req_in)
        begin
          state_next = ST_RP_WAIT;
        end
        else if (got_word_reg && (pause_req_in || near_full))
        begin
          state_next = ST_PAUSE;
        end
      end
      ST_PAUSE:
      begin
        if (stop_lvl)
        begin
          state_next = ST_HALT;
        end
        else if (term_req_in)
        begin
          state_next = ST_RP_WAIT;
        end
        else if (!pause_req_in && !near_full)
        begin
          state_next = ST_XFER;
        end
      end
      ST_RP_WAIT:
      begin
        if (stop_lvl || (rp_cnt_reg == 8'h00))
        begin
          state_next = ST_HALT;
        end
      end
      ST_HALT:
      begin
        if (!dmack_act)
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Words count only while request is still up; later strobe edges are void.
  assign take_word = strobe_edge && ((state_reg == ST_XFER) || (state_reg == ST_PAUSE) ||
                                     (state_reg == ST_RP_WAIT));

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      got_word_reg <= 1'b0;
    end
    else if (state_reg == ST_IDLE)
    begin
      got_word_reg <= 1'b0;
    end
    else if (take_word)
    begin
      got_word_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rp_cnt_reg <= RP_LOAD;
    end
    else if (state_reg != ST_RP_WAIT)
    begin
      rp_cnt_reg <= RP_LOAD;
    end
    else if (rp_cnt_reg != 8'h00)
    begin
      rp_cnt_reg <= rp_cnt_reg - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers.

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      dmarq_out        <= 1'b0;
      ddmardy_n_out    <= 1'b1;
      ddmardy_oe_out   <= 1'b0;
      burst_active_out <= 1'b0;
    end
    else
    begin
      dmarq_out        <= (state_next == ST_REQ) || (state_next == ST_XFER) ||
                          (state_next == ST_PAUSE) || (state_next == ST_RP_WAIT);
      ddmardy_n_out    <= (state_next != ST_XFER);
      ddmardy_oe_out   <= dmack_act && (state_next != ST_IDLE);
      burst_active_out <= (state_next != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // CRC generation and check.

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] d);
    logic [15:0] c;
    logic        fb;
    c  = crc;
    fb = 1'b0;
    for (int i = 0; i < DATA_W; i++)
    begin
      fb = d[i] ^ c[15];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : crc_step

  logic [15:0] crc_reg;
  logic        crc_check;
  logic        crc_bad;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      crc_reg <= CRC_SEED;
    end
    else if (state_reg == ST_IDLE)
    begin
      crc_reg <= CRC_SEED;
    end
    else if (take_word)
    begin
      crc_reg <= crc_step(crc_reg, data_word);
    end
  end

  assign crc_check = (state_reg == ST_HALT) && dmack_rise;
  assign crc_bad   = crc_check && (data_word != crc_reg);

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      burst_done_out <= 1'b0;
    end
    else
    begin
      burst_done_out <= crc_check;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-command error record.

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      crc_err_out <= 1'b0;
    end
    else if (crc_bad)
    begin
      crc_err_out <= 1'b1;
    end
    else if (cmd_start_in)
    begin
      crc_err_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      overrun_out <= 1'b0;
    end
    else if (take_word && !fifo_wr_ready)
    begin
      overrun_out <= 1'b1;
    end
    else if (cmd_start_in)
    begin
      overrun_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      err_reg_out <= ERR_RST;
    end
    else if (cmd_end_in)
    begin
      err_reg_out               <= ERR_RST;
      err_reg_out[ERR_ICRC_BIT] <= crc_err_out || crc_bad;
      err_reg_out[ERR_ABRT_BIT] <= crc_err_out || crc_bad;
    end
    else if (cmd_start_in)
    begin
      err_reg_out <= ERR_RST;
    end
  end

endmodule : udo_dout

//--- udo_dout_chk.sv
// Purpose: Concurrent checks on the drive-side data-out burst handshake.
// Assumes: One clock domain; asynchronous active-high reset.
// Notes:   Sees only the top module's ports.
module udo_dout_chk
  import udo_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  input wire logic       hstrobe_in,
  input wire logic       stop_in,
  input wire logic       dmack_n_in,
  input wire logic       dmarq_out,
  input wire logic       ddmardy_n_out,
  input wire logic       burst_req_in,
  input wire logic       cmd_start_in,
  input wire logic       cmd_end_in,
  input wire logic       burst_active_out,
  input wire logic       burst_done_out,
  input wire logic       crc_err_out,
  input wire logic       overrun_out,
  input wire logic [7:0] err_reg_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rdy_cnt_reg;
  logic       edge_seen_reg;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in || !ddmardy_n_out)
      rdy_cnt_reg <= 8'h00;
    else if (rdy_cnt_reg != 8'hFF)
      rdy_cnt_reg <= rdy_cnt_reg + 8'h01;
  end
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in || !burst_active_out)
      edge_seen_reg <= 1'b0;
    else if ($changed(hstrobe_in) && !ddmardy_n_out)
      edge_seen_reg <= 1'b1;
  end
  ////////////////////////////////////////
  chk_rq_recover:
  assert property ($fell(dmarq_out) |-> rdy_cnt_reg >= RP_CYCLES || $past(stop_in, 2))
    else $error("request dropped too early");
  chk_rq_start:
  assert property ($rose(dmarq_out) |-> $past(burst_req_in) && !$past(burst_active_out))
    else $error("request raised inside a burst");
  chk_stop_answer:
  assert property ($rose(stop_in) && dmarq_out && !ddmardy_n_out |-> ##[1:6] !dmarq_out && ddmardy_n_out)
    else $error("no answer to host stop");
  chk_rdy_hold:
  assert property (!dmarq_out && burst_active_out && ddmardy_n_out |=> ddmardy_n_out)
    else $error("ready reasserted after request drop");
  chk_first_word:
  assert property ($rose(ddmardy_n_out) && dmarq_out && !$past(stop_in, 2) |-> edge_seen_reg)
    else $error("pause before first word");
  chk_done_ack:
  assert property ($rose(dmack_n_in) && burst_active_out |-> ##[2:6] burst_done_out)
    else $error("no check after acknowledge");
  chk_crc_sticky:
  assert property (crc_err_out && !cmd_start_in |=> crc_err_out)
    else $error("saved error lost");
  chk_err_report:
  assert property (cmd_end_in && crc_err_out && !cmd_start_in |=> err_reg_out == 8'h84)
    else $error("error byte wrong");
  chk_no_overrun:
  assert property (!overrun_out)
    else $error("word lost");
  cover property ($fell(dmarq_out) && rdy_cnt_reg >= RP_CYCLES);
  cover property (burst_done_out && crc_err_out);
  cover property ($rose(ddmardy_n_out) && dmarq_out);
endmodule : udo_dout_chk

bind udo_dout udo_dout_chk u_chk (.*);

//--- udo_host.sv
// Purpose: Host model driving data-out bursts into the drive.
// Assumes: Strobe edges 62 ns apart, data set 20 ns before each edge.
// Notes:   Keeps its own CRC and the list of words sent.
module udo_host
  import udo_pkg::*;
(
  input  wire logic         dmarq_in,
  input  wire logic         ddmardy_n_in,
  output logic              hstrobe_out,
  output logic              stop_out,
  output logic              dmack_n_out,
  output logic [DATA_W-1:0] dd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] crc;
  logic [15:0] sent[$];
  initial
  begin
    hstrobe_out = 1'b1;
    stop_out = 1'b1;
    dmack_n_out = 1'b1;
    dd_out = 16'h0000;
  end
  task automatic burst(input int n, input bit hterm, input bit bad);
    int i;
    i = 0;
    crc = CRC_SEED;
    wait (dmarq_in);
    #40 dmack_n_out = 1'b0;
    #40 stop_out = 1'b0;
    while (i < n && dmarq_in)
    begin
      if (!ddmardy_n_in)
      begin
        dd_out = 16'(i * 16'h1357 + 16'h00A5);
        #20 hstrobe_out = ~hstrobe_out;
        for (int b = 0; b < 16; b++)
          crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ dd_out[b]) ? CRC_POLY : 16'h0000);
        sent.push_back(dd_out);
        i++;
        #42;
      end
      else
        #8;
    end
    if (hterm)
      #40 stop_out = 1'b1;
    wait (!dmarq_in);
    stop_out = 1'b1;
    #20 hstrobe_out = 1'b1;
    dd_out = crc ^ {15'h0000, bad};
    #60 dmack_n_out = 1'b1;
    #20 dd_out = ~dd_out;
  endtask : burst
endmodule : udo_host

//--- udo_dout_test.sv
// Purpose: Self-checking bench for the data-out burst handshake.
// Assumes: Host model udo_host stands on the link side.
// Notes:   Control inputs change on the falling clock edge; udo_host drives the link pins on its own delays.
module udo_dout_test
  import udo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hs, stop, ack_n, rq, rdy_n, oe, active, done, crc_err, ovr, valid;
  logic        breq = 1'b0, pause = 1'b0, term = 1'b0, cstart = 1'b0, cend = 1'b0;
  logic        ready = 1'b1;
  logic [15:0] dd, word;
  logic [7:0]  err;
  logic [15:0] rx[$];
  int          failures = 0, compares = 0, cycles = 0;
  wire         rdy_pin = oe ? rdy_n : 1'b1;
  udo_dout u_dut (.clk_in(clk), .sys_rst_in(rst), .hstrobe_in(hs), .stop_in(stop),
    .dmack_n_in(ack_n), .dd_in(dd), .dmarq_out(rq), .ddmardy_n_out(rdy_n),
    .ddmardy_oe_out(oe), .burst_req_in(breq), .pause_req_in(pause), .term_req_in(term),
    .cmd_start_in(cstart), .cmd_end_in(cend), .word_out(word), .word_valid_out(valid),
    .word_ready_in(ready), .burst_active_out(active), .burst_done_out(done),
    .crc_err_out(crc_err), .overrun_out(ovr), .err_reg_out(err));
  udo_host u_host (.dmarq_in(rq), .ddmardy_n_in(rdy_pin), .hstrobe_out(hs),
    .stop_out(stop), .dmack_n_out(ack_n), .dd_out(dd));
  ////////////////////////////////////////
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      stop_test();
    end
  end
  always @(posedge clk)
    if (valid === 1'b1 && ready === 1'b1)
      rx.push_back(word);
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic run(input int n, input bit hterm, input bit bad);
    fork
      begin
        @(negedge clk) breq = 1'b1;
        @(negedge clk) breq = 1'b0;
        while (done !== 1'b1)
          @(negedge clk);
      end
      u_host.burst(n, hterm, bad);
    join
    repeat (40) @(negedge clk);
    check(16'(rx.size()), 16'(u_host.sent.size()));
    foreach (rx[i]) check(rx[i], u_host.sent[i]);
    check(16'({rq, active}), 16'h0000);
    rx.delete();
    u_host.sent.delete();
  endtask : run
  task automatic t_host_term;
    run(5, 1'b1, 1'b0);
    check(16'(crc_err), 16'h0000);
    $display("host termination done");
  endtask : t_host_term
  task automatic t_dev_term;
    fork
      run(200, 1'b0, 1'b0);
      begin
        while (rx.size() < 6)
          @(negedge clk);
        term = 1'b1;
        repeat (3) @(negedge clk);
        check(16'({rq, rdy_n}), 16'h0003);
        while (done !== 1'b1)
          @(negedge clk);
        term = 1'b0;
      end
    join
    check(16'(crc_err), 16'h0000);
    $display("device termination done");
  endtask : t_dev_term
  task automatic t_pause;
    pause = 1'b1;
    ready = 1'b0;
    fork
      run(30, 1'b1, 1'b0);
      begin
        repeat (100) @(negedge clk);
        check(16'(rdy_n), 16'h0001);
        pause = 1'b0;
        repeat (150) @(negedge clk);
        check(16'({rdy_n, ovr}), 16'h0002);
        check(16'(u_host.sent.size() >= 13), 16'h0001);
        ready = 1'b1;
      end
    join
    $display("pause and buffer fill done");
  endtask : t_pause
  task automatic t_crc;
    run(4, 1'b1, 1'b1);
    check(16'(crc_err), 16'h0001);
    run(3, 1'b1, 1'b0);
    check(16'(crc_err), 16'h0001);
    @(negedge clk) cend = 1'b1;
    @(negedge clk) cend = 1'b0;
    check(16'(err), 16'h0084);
    cstart = 1'b1;
    @(negedge clk) cstart = 1'b0;
    check(16'({crc_err, err}), 16'h0000);
    $display("crc error done");
  endtask : t_crc
  ////////////////////////////////////////
  initial
  begin
    repeat (6) @(negedge clk);
    check(16'({rq, rdy_n, oe, done}), 16'h0004);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_host_term();
    t_dev_term();
    t_pause();
    t_crc();
    stop_test();
  end
endmodule : udo_dout_test
